// file: rtl/dual_half_timer.sv
// Dual 32-bit timer with unchained and chained arrangements, APB slave.
// Assumes APB3 on pclk; ext_clk_in is a slow input sampled on pclk.
`timescale 1ns/1ps
`include "timer_defs.svh"
// Summary of operation
// - arrangement value 1 selects independent halves
// - in arrangement 1 high half prescaled, low half counts directly
// - high half prescaler uses internal clock only
// - prescaler pulses cycle after matching its period
// - high match raises interrupt, event, output in arrangement 1 only
// - continuous count returns to zero on the half's next tick
// - low match raises interrupt, event, output
// - in arrangement 1 each run bit stops only its half, count held
// - modes: stop-hold, one-shot, continuous
// - low control bits ignored by high half in arrangement 1
// - high control bits ignored by low half in arrangement 1
// - external clock synchronised, low half in arrangement 1, high prescaler in 3
// - zero count and period never increments
// - counters and periods mapped per arrangement
// - arrangement 3 chains high prescaler into low
// - active timer blocks all but mode/run writes
module dual_half_timer #(
    parameter int ADDR_W = 8
) (
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Timer pins and events
    input wire logic ext_clk_in,
    output logic timer_output_pin,
    output logic low_half_interrupt,
    output logic low_half_dma_event,
    output logic high_half_interrupt,
    output logic high_half_dma_event
);
    import timer_pkg::*;

    logic [31:0] low_half_period_r, high_half_period_r;
    logic [31:0] timer_control_reg_r, global_control_reg_r;
    logic [3:0] prescale_count_field_r;
    logic psc_tick_r, chain_tick_r, toggle_r;
    logic ext_s1_r, ext_s2_r, ext_prev_r;
    logic [1:0] pw_cnt_r;
    logic [31:0] rdata_nxt, low_half_count, high_half_count;
    logic low_hit, high_hit;

    // Field views
    logic [1:0] half_arrangement_select, pulse_width_select;
    logic [3:0] prescale_period_field;
    logic low_half_run_bit, high_half_run_bit;
    half_mode_e low_half_enable_mode, high_half_enable_mode;
    logic low_half_clock_source, output_clock_pulse_select;
    logic input_invert, output_invert;

    assign half_arrangement_select =
        global_control_reg_r[`GCR_ARR_LO +: 2];
    assign prescale_period_field = global_control_reg_r[`GCR_PSC_LO +: 4];
    assign low_half_run_bit = global_control_reg_r[`GCR_LOW_RUN];
    assign high_half_run_bit = global_control_reg_r[`GCR_HIGH_RUN];
    // Low half sees only the lower control half, high half the upper in arrangement 1
    assign low_half_enable_mode = half_mode_e'(
        timer_control_reg_r[`TCR_LOW_MODE_LO +: 2]);
    assign high_half_enable_mode = half_mode_e'(
        timer_control_reg_r[`TCR_HIGH_MODE_LO +: 2]);
    assign low_half_clock_source = timer_control_reg_r[`TCR_LOW_CLOCK_SOURCE_SELECT];
    assign output_clock_pulse_select = timer_control_reg_r[`TCR_PULSE_SEL];
    assign pulse_width_select = timer_control_reg_r[`TCR_PULSE_WIDTH_SELECT_LO +: 2];
    assign input_invert = timer_control_reg_r[`TCR_IN_INV];
    assign output_invert = timer_control_reg_r[`TCR_OUT_INV];

    logic unchained, chained;
    assign unchained = (half_arrangement_select == `ARR_UNCHAINED);
    assign chained = (half_arrangement_select == `ARR_CHAINED);

    // Per-arrangement control of each half
    half_ctl_s low_ctl, high_ctl;
    always_comb begin
        low_ctl = '{run: 1'b0, mode: EN_DISABLED};
        high_ctl = '{run: 1'b0, mode: EN_DISABLED};
        if (unchained) begin
            low_ctl = '{run: low_half_run_bit, mode: low_half_enable_mode};
            high_ctl = '{run: high_half_run_bit,
                mode: high_half_enable_mode};
        end else if (chained) begin
            // The prescaler free-runs whenever the timer is enabled
            low_ctl = '{run: low_half_run_bit && high_half_run_bit,
                mode: low_half_enable_mode};
            high_ctl = '{run: low_ctl.run,
                mode: is_active(low_ctl) ? EN_CONTINUOUS : EN_DISABLED};
        end
    end

    logic low_act, high_act, any_active;
    assign low_act = is_active(low_ctl);
    assign high_act = is_active(high_ctl);
    assign any_active = low_act || high_act;

    // External clock: two-flop synchroniser, then rising-edge detect
    logic ext_level, ext_rise;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
            ext_prev_r <= 1'b0;
        end else begin
            ext_s1_r <= ext_clk_in;
            ext_s2_r <= ext_s1_r;
            ext_prev_r <= ext_level;
        end
    end
    assign ext_level = ext_s2_r ^ input_invert;
    assign ext_rise = ext_level && !ext_prev_r;

    // The low half takes the external clock in arrangement 1, the high prescaler in arrangement 3
    logic src_tick;
    assign src_tick = low_half_clock_source ? ext_rise : 1'b1;

    // Four-bit prescaler of the unchained high half, internal clock only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale_count_field_r <= `PSC_RESET;
            psc_tick_r <= 1'b0;
        end else if (unchained && high_act) begin
            if (prescale_count_field_r == prescale_period_field) begin
                prescale_count_field_r <= `PSC_RESET;
                psc_tick_r <= 1'b1;
            end else begin
                prescale_count_field_r <= prescale_count_field_r + 4'h1;
                psc_tick_r <= 1'b0;
            end
        end else begin
            psc_tick_r <= 1'b0;
        end
    end

    // Chained: 32-bit prescaler clocks the low timer a cycle after match
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chain_tick_r <= 1'b0;
        end else begin
            chain_tick_r <= chained && high_act && src_tick &&
                (high_half_count == high_half_period_r);
        end
    end

    logic low_tick, high_tick;
    assign low_tick = chained ? chain_tick_r : src_tick;
    assign high_tick = chained ? src_tick : psc_tick_r;

    // APB handshake: one wait-free access phase after each setup
    logic setup, wr_acc;
    assign setup = psel && !penable;
    assign wr_acc = psel && penable && pready && pwrite;

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        return a == ADDR_W'(`OFS_LOW_COUNT) ||
            a == ADDR_W'(`OFS_HIGH_COUNT) ||
            a == ADDR_W'(`OFS_LOW_PERIOD) ||
            a == ADDR_W'(`OFS_HIGH_PERIOD) ||
            a == ADDR_W'(`OFS_TIMER_CTL) ||
            a == ADDR_W'(`OFS_GLOBAL_CTL);
    endfunction

    function automatic logic wr_to(input logic [ADDR_W-1:0] a,
        input logic [7:0] ofs);
        return a == ADDR_W'(ofs);
    endfunction

    // Counter and period writes are dropped while any half is active
    logic wr_open, low_load, high_load;
    assign wr_open = wr_acc && !any_active;
    assign low_load = wr_open && wr_to(paddr, `OFS_LOW_COUNT);
    assign high_load = wr_open && wr_to(paddr, `OFS_HIGH_COUNT);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_half_period_r <= `REG_RESET;
            high_half_period_r <= `REG_RESET;
        end else if (wr_open) begin
            if (wr_to(paddr, `OFS_LOW_PERIOD)) begin
                low_half_period_r <= pwdata;
            end else if (wr_to(paddr, `OFS_HIGH_PERIOD)) begin
                high_half_period_r <= pwdata;
            end
        end
    end

    // Only mode and run fields stay writable while active
    logic [31:0] tcr_mask, gcr_mask;
    assign tcr_mask = any_active ? `TCR_ACTIVE_MASK : `TCR_WR_MASK;
    assign gcr_mask = any_active ? `GCR_ACTIVE_MASK : `GCR_WR_MASK;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_control_reg_r <= `REG_RESET;
            global_control_reg_r <= `REG_RESET;
        end else if (wr_acc) begin
            if (wr_to(paddr, `OFS_TIMER_CTL)) begin
                timer_control_reg_r <= (timer_control_reg_r & ~tcr_mask) |
                    (pwdata & tcr_mask);
            end else if (wr_to(paddr, `OFS_GLOBAL_CTL)) begin
                global_control_reg_r <=
                    (global_control_reg_r & ~gcr_mask) | (pwdata & gcr_mask);
            end
        end
    end

    always_comb begin
        rdata_nxt = `REG_RESET;
        if (wr_to(paddr, `OFS_LOW_COUNT)) begin
            rdata_nxt = low_half_count;
        end else if (wr_to(paddr, `OFS_HIGH_COUNT)) begin
            rdata_nxt = high_half_count;
        end else if (wr_to(paddr, `OFS_LOW_PERIOD)) begin
            rdata_nxt = low_half_period_r;
        end else if (wr_to(paddr, `OFS_HIGH_PERIOD)) begin
            rdata_nxt = high_half_period_r;
        end else if (wr_to(paddr, `OFS_TIMER_CTL)) begin
            rdata_nxt = timer_control_reg_r;
        end else if (wr_to(paddr, `OFS_GLOBAL_CTL)) begin
            rdata_nxt = global_control_reg_r;
            rdata_nxt[`GCR_TDDR_LO +: 4] = prescale_count_field_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= `REG_RESET;
        end else begin
            pready <= setup;
            pslverr <= setup && !is_mapped(paddr);
            prdata <= (setup && !pwrite) ? rdata_nxt : `REG_RESET;
        end
    end

    half_counter #(.WIDTH(32)) u_low (
        .pclk(pclk),
        .presetn(presetn),
        .ctl(low_ctl),
        .tick(low_tick),
        .period(low_half_period_r),
        .load_en(low_load),
        .load_val(pwdata),
        .count_r(low_half_count),
        .hit_r(low_hit)
    );

    half_counter #(.WIDTH(32)) u_high (
        .pclk(pclk),
        .presetn(presetn),
        .ctl(high_ctl),
        .tick(high_tick),
        .period(high_half_period_r),
        .load_en(high_load),
        .load_val(pwdata),
        .count_r(high_half_count),
        .hit_r(high_hit)
    );

    // A chained prescaler match is not a timer event
    logic high_evt;
    assign high_evt = unchained && high_hit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_half_interrupt <= 1'b0;
            low_half_dma_event <= 1'b0;
            high_half_interrupt <= 1'b0;
            high_half_dma_event <= 1'b0;
        end else begin
            low_half_interrupt <= low_hit;
            low_half_dma_event <= low_hit;
            high_half_interrupt <= high_evt;
            high_half_dma_event <= high_evt;
        end
    end

    // Output pin: pulse of one to four cycles, or toggle in clock mode
    logic pin_evt;
    assign pin_evt = low_hit || high_evt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pw_cnt_r <= 2'h0;
            toggle_r <= 1'b0;
            timer_output_pin <= 1'b0;
        end else begin
            if (pin_evt) begin
                pw_cnt_r <= pulse_width_select;
                toggle_r <= !toggle_r;
            end else if (pw_cnt_r != 2'h0) begin
                pw_cnt_r <= pw_cnt_r - 2'h1;
            end
            timer_output_pin <= output_invert ^ (output_clock_pulse_select ?
                toggle_r : (pin_evt || pw_cnt_r != 2'h0));
        end
    end

    psc_tick_a: assert property (@(posedge pclk) disable iff (!presetn)
        psc_tick_r |-> $past(prescale_count_field_r) ==
        $past(prescale_period_field))
        else $error("prescale pulse without prior period match");
    psc_restart_a: assert property (@(posedge pclk) disable iff (!presetn)
        psc_tick_r |-> prescale_count_field_r == 4'h0)
        else $error("prescale count did not restart at zero");
    low_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
        low_hit |=> low_half_interrupt && low_half_dma_event)
        else $error("low match raised no interrupt and event");
    high_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
        high_half_interrupt |-> $past(unchained) && $past(high_hit))
        else $error("high interrupt without unchained match");
    period_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
        any_active && wr_acc |=> $stable(low_half_period_r) &&
        $stable(high_half_period_r))
        else $error("period written while timer active");
    arr_select_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_acc && !any_active && wr_to(paddr, `OFS_GLOBAL_CTL) &&
        pwdata[`GCR_ARR_LO +: 2] == `ARR_UNCHAINED |=> unchained)
        else $error("arrangement 1 not taken");
    high_no_ext_a: assert property (@(posedge pclk) disable iff (!presetn)
        unchained && high_act && prescale_period_field != 4'h0
        |=> prescale_count_field_r != $past(prescale_count_field_r))
        else $error("unchained prescaler stalled on internal clock");
endmodule

// file: rtl/timer_defs.svh
// Register offsets, field positions and masks of the dual half timer.
// Included by the timer modules; holds definitions only.
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH

`define OFS_LOW_COUNT 8'h10
`define OFS_HIGH_COUNT 8'h14
`define OFS_LOW_PERIOD 8'h18
`define OFS_HIGH_PERIOD 8'h1C
`define OFS_TIMER_CTL 8'h20
`define OFS_GLOBAL_CTL 8'h24

`define TCR_OUT_INV 2
`define TCR_PULSE_SEL 3
`define TCR_PULSE_WIDTH_SELECT_LO 4
`define TCR_LOW_MODE_LO 6
`define TCR_LOW_CLOCK_SOURCE_SELECT 8
`define TCR_IN_INV 9
`define TCR_HIGH_MODE_LO 22

`define GCR_LOW_RUN 0
`define GCR_HIGH_RUN 1
`define GCR_ARR_LO 2
`define GCR_PSC_LO 8
`define GCR_TDDR_LO 12

`define ARR_UNCHAINED 2'h1
`define ARR_CHAINED 2'h3

`define TCR_WR_MASK 32'h00C003FC
`define TCR_ACTIVE_MASK 32'h00C000C0
`define GCR_WR_MASK 32'h00000F0F
`define GCR_ACTIVE_MASK 32'h00000003

`define REG_RESET 32'h00000000
`define PSC_RESET 4'h0

`endif

// file: rtl/timer_pkg.sv
// Types shared by the dual half timer modules.
// Needs nothing from its surroundings.
package timer_pkg;
    typedef enum logic [1:0] {
        EN_DISABLED,
        EN_ONE_SHOT,
        EN_CONTINUOUS,
        EN_RESERVED
    } half_mode_e;

    typedef struct packed {
        logic run;
        half_mode_e mode;
    } half_ctl_s;

    function automatic logic is_active(input half_ctl_s c);
        return c.run && (c.mode == EN_ONE_SHOT || c.mode == EN_CONTINUOUS);
    endfunction
endpackage

// file: rtl/half_counter.sv
// One 32-bit half counter with period match and enable mode.
// Assumes tick is a one-cycle count request on pclk.
`timescale 1ns/1ps
`include "timer_defs.svh"
module half_counter #(
    parameter int WIDTH = 32
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input timer_pkg::half_ctl_s ctl,
    input wire logic tick,
    input wire logic [WIDTH-1:0] period,
    input wire logic load_en,
    input wire logic [WIDTH-1:0] load_val,
    // State
    output logic [WIDTH-1:0] count_r,
    output logic hit_r
);
    import timer_pkg::*;

    logic act;
    logic [WIDTH-1:0] count_inc;
    logic at_period;

    assign act = is_active(ctl);
    assign count_inc = count_r + 1'b1;
    assign at_period = (count_r == period);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_r <= '0;
        end else if (load_en) begin
            count_r <= load_val;
        end else if (act && tick && at_period) begin
            // Wrap on the half's own next tick so a prescaled half keeps
            // its full period; one-shot parks on the period
            if (ctl.mode == EN_CONTINUOUS) begin
                count_r <= '0;
            end
        end else if (act && tick) begin
            count_r <= count_inc;
        end
    end

    // Zero count with zero period sits on the period and never counts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hit_r <= 1'b0;
        end else begin
            hit_r <= act && tick && !load_en && !at_period &&
                (count_inc == period);
        end
    end

    hit_period_a: assert property (@(posedge pclk) disable iff (!presetn)
        hit_r |-> count_r == period)
        else $error("match pulse without count at period");

    wrap_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        act && tick && at_period && ctl.mode == EN_CONTINUOUS && !load_en
        |=> count_r == '0)
        else $error("continuous count did not wrap to zero");

    stop_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!ctl.run || ctl.mode == EN_DISABLED) && !load_en
        |=> $stable(count_r) && !hit_r)
        else $error("stopped half changed its count");

    zero_period_a: assert property (@(posedge pclk) disable iff (!presetn)
        count_r == '0 && period == '0 && !load_en
        |=> count_r == '0)
        else $error("count moved with zero period");

    one_shot_a: assert property (@(posedge pclk) disable iff (!presetn)
        act && at_period && ctl.mode == EN_ONE_SHOT && !load_en
        |=> $stable(count_r))
        else $error("one-shot count ran past the period");
endmodule

// file: tb/dual_half_timer_test.sv
// Self-checking bench for the dual half timer in its unchained and chained arrangements.
// Assumes rtl/timer_defs.svh on the include path and a 100 MHz pclk.
`timescale 1ns/1ps
`include "timer_defs.svh"
module dual_half_timer_test;
    import timer_pkg::*;

    logic pclk, presetn, psel, penable, pwrite, ext_clk_in;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, timer_output_pin;
    logic low_half_interrupt, low_half_dma_event;
    logic high_half_interrupt, high_half_dma_event;
    int fails = 0;
    int tests_run = 0;

    dual_half_timer #(.ADDR_W(8)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_clk_in(ext_clk_in),
        .timer_output_pin(timer_output_pin),
        .low_half_interrupt(low_half_interrupt),
        .low_half_dma_event(low_half_dma_event),
        .high_half_interrupt(high_half_interrupt),
        .high_half_dma_event(high_half_dma_event)
    );

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic finish_test();
        if (fails == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t: word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t: bit %b expected %b", $time, got, exp);
        end
    endtask

    task automatic check_num(input int got, input int exp);
        tests_run++;
        if (got != exp) begin
            fails++;
            $display("ERROR %0t: count %0d expected %0d", $time, got, exp);
        end
    endtask

    // Holds the request until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog bounds this wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd_check(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        check_word(q, exp);
        check_bit(e, 1'b0);
    endtask

    // Counts interrupt pulses of one half over a span of cycles
    task automatic pulses(input bit hi, input int cyc, output int cnt);
        logic s, d;
        cnt = 0;
        repeat (cyc) begin
            @(posedge pclk);
            #1;
            s = hi ? high_half_interrupt : low_half_interrupt;
            d = hi ? high_half_dma_event : low_half_dma_event;
            if (s === 1'b1) begin
                cnt++;
                check_bit(d, 1'b1);
            end
        end
    endtask

    // Cycles between two successive interrupt pulses of one half
    task automatic gap(input bit hi, input int exp);
        int n;
        int k;
        logic s;
        for (k = 0; k < 2; k++) begin
            n = 0;
            do begin
                @(posedge pclk);
                #1;
                n++;
                s = hi ? high_half_interrupt : low_half_interrupt;
            end while (s !== 1'b1 && n < 300);
            if (hi)
                check_bit(high_half_dma_event, 1'b1);
            else
                check_bit(low_half_dma_event, 1'b1);
        end
        check_num(n, exp);
    endtask

    task automatic t_reset();
        logic [31:0] q;
        logic e;
        rd_check(`OFS_LOW_COUNT, `REG_RESET);
        rd_check(`OFS_HIGH_COUNT, `REG_RESET);
        rd_check(`OFS_LOW_PERIOD, `REG_RESET);
        rd_check(`OFS_HIGH_PERIOD, `REG_RESET);
        rd_check(`OFS_TIMER_CTL, `REG_RESET);
        rd_check(`OFS_GLOBAL_CTL, `REG_RESET);
        apb(1'b0, 8'h30, 32'h0, q, e);
        check_bit(e, 1'b1);
        check_word(q, 32'h00000000);
    endtask

    task automatic t_zero();
        int c;
        wr(`OFS_GLOBAL_CTL, 32'h00000005);
        wr(`OFS_TIMER_CTL, 32'h00000080);
        pulses(1'b0, 20, c);
        check_num(c, 0);
        wr(`OFS_TIMER_CTL, 32'h00000000);
        rd_check(`OFS_LOW_COUNT, 32'h00000000);
    endtask

    task automatic t_low();
        int c;
        logic [31:0] q;
        logic e;
        wr(`OFS_LOW_PERIOD, 32'h00000003);
        wr(`OFS_TIMER_CTL, 32'h00000080);
        gap(1'b0, 4);
        check_bit(timer_output_pin, 1'b1);
        @(posedge pclk);
        #1;
        check_bit(timer_output_pin, 1'b0);
        // Period write lands while the half is active and must be dropped
        wr(`OFS_LOW_PERIOD, 32'h00000009);
        gap(1'b0, 4);
        rd_check(`OFS_LOW_PERIOD, 32'h00000003);
        wr(`OFS_GLOBAL_CTL, 32'h00000004);
        apb(1'b0, `OFS_LOW_COUNT, 32'h0, q, e);
        pulses(1'b0, 12, c);
        check_num(c, 0);
        rd_check(`OFS_LOW_COUNT, q);
        wr(`OFS_TIMER_CTL, 32'h00000000);
        wr(`OFS_GLOBAL_CTL, 32'h00000005);
        wr(`OFS_LOW_COUNT, 32'h00000000);
        wr(`OFS_LOW_PERIOD, 32'h00000005);
        wr(`OFS_TIMER_CTL, 32'h00000040);
        pulses(1'b0, 30, c);
        check_num(c, 1);
        rd_check(`OFS_LOW_COUNT, 32'h00000005);
        wr(`OFS_TIMER_CTL, 32'h00000000);
    endtask

    task automatic t_high();
        int c;
        logic p;
        wr(`OFS_LOW_COUNT, 32'h00000000);
        wr(`OFS_LOW_PERIOD, 32'h00000003);
        wr(`OFS_GLOBAL_CTL, 32'h00000007);
        wr(`OFS_HIGH_PERIOD, 32'h00000002);
        wr(`OFS_GLOBAL_CTL, 32'h00000107);
        // Odd low-half options must not disturb the prescaled half
        wr(`OFS_TIMER_CTL, 32'h0080033C);
        gap(1'b1, 6);
        // Toggle mode: the pin flips one cycle after the event
        p = timer_output_pin;
        @(posedge pclk);
        #1;
        check_bit(timer_output_pin, !p);
        pulses(1'b0, 20, c);
        check_num(c, 0);
        wr(`OFS_GLOBAL_CTL, 32'h00000105);
        wr(`OFS_TIMER_CTL, 32'h00800080);
        gap(1'b0, 4);
        pulses(1'b1, 24, c);
        check_num(c, 0);
        wr(`OFS_TIMER_CTL, 32'h00000000);
    endtask

    task automatic t_ext();
        wr(`OFS_LOW_COUNT, 32'h00000000);
        wr(`OFS_LOW_PERIOD, 32'h00000100);
        wr(`OFS_TIMER_CTL, 32'h00000180);
        repeat (5) begin
            repeat (3) @(posedge pclk);
            ext_clk_in <= 1'b1;
            repeat (3) @(posedge pclk);
            ext_clk_in <= 1'b0;
        end
        repeat (10) @(posedge pclk);
        rd_check(`OFS_LOW_COUNT, 32'h00000005);
        wr(`OFS_TIMER_CTL, 32'h00000100);
        // Stay disabled well over one external period before any restart
        repeat (12) @(posedge pclk);
    endtask

    // Chained: high pair divides by two, low timer period of three ticks
    task automatic t_chain();
        int c;
        wr(`OFS_LOW_COUNT, 32'h00000000);
        wr(`OFS_HIGH_COUNT, 32'h00000000);
        wr(`OFS_TIMER_CTL, 32'h00000000);
        wr(`OFS_GLOBAL_CTL, 32'h0000000F);
        wr(`OFS_LOW_PERIOD, 32'h00000002);
        wr(`OFS_HIGH_PERIOD, 32'h00000001);
        wr(`OFS_TIMER_CTL, 32'h00000080);
        gap(1'b0, 6);
        pulses(1'b1, 20, c);
        check_num(c, 0);
        wr(`OFS_TIMER_CTL, 32'h00000000);
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        ext_clk_in = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_zero();
        t_low();
        t_high();
        t_ext();
        t_chain();
        finish_test();
    end

    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        $display("ERROR %0t: watchdog expired", $time);
        finish_test();
    end
endmodule
